// *** rtl/cmpc_channel.sv ***
/*
  cmpc_channel: one comparator channel: enable, hysteresis and speed
  settings, sticky edge flags with masks, latched and raw outputs.
  Assumes the raw comparator input is asynchronous to mclk.
*/
`timescale 1ns/1ns
module cmpc_channel
  import cmpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register writes, already decoded
  input wire logic ctrl_wr,
  input wire logic speed_wr,
  input wire logic [7:0] wdata,
  // analog core
  input wire logic compare_raw,
  output logic power_on,
  output logic [1:0] positive_hysteresis_sel,
  output logic [1:0] negative_hysteresis_sel,
  output logic [1:0] response_speed_sel,
  // readback and events
  output logic [7:0] ctrl_rdata,
  output logic [7:0] speed_rdata,
  output logic irq_req,
  // port-side outputs
  output logic latched_result_pin,
  output logic raw_result_pin
);
  logic channel_enable_q;
  logic rise_event_flag_q;
  logic fall_event_flag_q;
  logic rise_irq_mask_q;
  logic fall_irq_mask_q;
  logic [1:0] hyp_q;
  logic [1:0] hyn_q;
  logic [1:0] speed_q;
  logic sync1_q;
  logic compare_result_q;
  logic prev_q;
  logic rise_hit;
  logic fall_hit;

  // enable and hysteresis settings
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      channel_enable_q <= CMPC_CTRL_RST[CMPC_EN_BIT];
      hyp_q <= CMPC_HYST_RST;
      hyn_q <= CMPC_HYST_RST;
    end else if (ctrl_wr) begin
      channel_enable_q <= wdata[CMPC_EN_BIT];
      hyp_q <= wdata[CMPC_HYP_LSB +: 2];
      hyn_q <= wdata[CMPC_HYN_LSB +: 2];
    end
  end

  // masks and response time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_irq_mask_q <= 1'b0;
      fall_irq_mask_q <= 1'b0;
      speed_q <= CMPC_SPEED_RST;
    end else if (speed_wr) begin
      rise_irq_mask_q <= wdata[CMPC_RMASK_BIT];
      fall_irq_mask_q <= wdata[CMPC_FMASK_BIT];
      speed_q <= wdata[CMPC_SPEED_LSB +: 2];
    end
  end

  // two-stage synchroniser, then one more stage for edge detect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      compare_result_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= compare_raw;
      compare_result_q <= sync1_q;
      prev_q <= compare_result_q;
    end
  end

  assign rise_hit = compare_result_q & ~prev_q;
  assign fall_hit = ~compare_result_q & prev_q;

  // sticky flags: hardware only sets, set beats a same-cycle write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rise_event_flag_q <= 1'b0;
      fall_event_flag_q <= 1'b0;
    end else begin
      if (rise_hit) begin
        rise_event_flag_q <= 1'b1;
      end else if (ctrl_wr) begin
        rise_event_flag_q <= wdata[CMPC_RISE_BIT];
      end
      if (fall_hit) begin
        fall_event_flag_q <= 1'b1;
      end else if (ctrl_wr) begin
        fall_event_flag_q <= wdata[CMPC_FALL_BIT];
      end
    end
  end

  assign irq_req = (rise_event_flag_q & rise_irq_mask_q) | (fall_event_flag_q & fall_irq_mask_q);
  assign power_on = channel_enable_q;
  assign positive_hysteresis_sel = hyp_q;
  assign negative_hysteresis_sel = hyn_q;
  assign response_speed_sel = speed_q;
  // raw path bypasses the synchroniser flops, gated only by the enable flop, so it still works with the clock stopped
  assign raw_result_pin = compare_raw & channel_enable_q;
  assign latched_result_pin = compare_result_q & channel_enable_q;
  assign ctrl_rdata = {channel_enable_q, compare_result_q, rise_event_flag_q, fall_event_flag_q,
                       hyp_q, hyn_q};
  assign speed_rdata = {2'h0, rise_irq_mask_q, fall_irq_mask_q, 2'h0, speed_q};
endmodule // cmpc_channel

// *** include/cmpc_pkg.sv ***
/*
  cmpc_pkg: register offsets, field positions and reset values for the
  comparator control block.
  Assumes an 8-bit special-function register bus with byte addresses.
*/
package cmpc_pkg;
  // control and speed register addresses, channel zero then channel one
  localparam logic [7:0] CMPC_CTRL0_ADDR = 8'h9b;
  localparam logic [7:0] CMPC_SPEED0_ADDR = 8'h9d;
  localparam logic [7:0] CMPC_CTRL1_ADDR = 8'h9a;
  localparam logic [7:0] CMPC_SPEED1_ADDR = 8'h9c;
  // control register fields
  localparam int CMPC_EN_BIT = 7;
  localparam int CMPC_OUT_BIT = 6;
  localparam int CMPC_RISE_BIT = 5;
  localparam int CMPC_FALL_BIT = 4;
  localparam int CMPC_HYP_LSB = 2;
  localparam int CMPC_HYN_LSB = 0;
  // speed register fields
  localparam int CMPC_RMASK_BIT = 5;
  localparam int CMPC_FMASK_BIT = 4;
  localparam int CMPC_SPEED_LSB = 0;
  // reset values
  localparam logic [7:0] CMPC_CTRL_RST = 8'h00;
  localparam logic [1:0] CMPC_SPEED_RST = 2'h2;
  localparam logic [1:0] CMPC_HYST_RST = 2'h0;
  // synchroniser depth in cycles
  localparam int CMPC_SYNC_STAGES = 2;
endpackage

// *** rtl/cmpc_top.sv ***
/*
  cmpc_top: two comparator control channels behind the special-function
  register bus; channel zero can request a system reset.
  Assumes a single-cycle sfr bus: write strobe with address and data,
  read data combinational from the address.
*/
`timescale 1ns/1ns
module cmpc_top
  import cmpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // sfr bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // analog cores
  input wire logic [1:0] compare_raw,
  output logic [1:0] power_on,
  output logic [3:0] positive_hysteresis_sel,
  output logic [3:0] negative_hysteresis_sel,
  output logic [3:0] response_speed_sel,
  // system
  input wire logic reset_source_sel,
  output logic reset_req,
  output logic [1:0] irq_req,
  // port pins
  output logic latched_result_pin,
  output logic raw_result_pin,
  output logic latched_result_pin_b,
  output logic raw_result_pin_b
);
  logic [1:0] ctrl_wr;
  logic [1:0] speed_wr;
  logic [7:0] ctrl_rd [2];
  logic [7:0] speed_rd [2];
  logic [1:0] latched;
  logic [1:0] raw;

  // address decode per channel
  assign ctrl_wr[0] = sfr_wr & (sfr_addr == CMPC_CTRL0_ADDR);
  assign ctrl_wr[1] = sfr_wr & (sfr_addr == CMPC_CTRL1_ADDR);
  assign speed_wr[0] = sfr_wr & (sfr_addr == CMPC_SPEED0_ADDR);
  assign speed_wr[1] = sfr_wr & (sfr_addr == CMPC_SPEED1_ADDR);

  // identical channels, only hookup differs
  for (genvar i = 0; i < 2; i++) begin : g_ch
    cmpc_channel u_ch (
      .mclk(mclk),
      .rst_b(rst_b),
      .ctrl_wr(ctrl_wr[i]),
      .speed_wr(speed_wr[i]),
      .wdata(sfr_wdata),
      .compare_raw(compare_raw[i]),
      .power_on(power_on[i]),
      .positive_hysteresis_sel(positive_hysteresis_sel[2*i +: 2]),
      .negative_hysteresis_sel(negative_hysteresis_sel[2*i +: 2]),
      .response_speed_sel(response_speed_sel[2*i +: 2]),
      .ctrl_rdata(ctrl_rd[i]),
      .speed_rdata(speed_rd[i]),
      .irq_req(irq_req[i]),
      .latched_result_pin(latched[i]),
      .raw_result_pin(raw[i])
    );
  end

  // readback mux; unmapped addresses read zero
  always_comb begin
    unique case (sfr_addr)
      CMPC_CTRL0_ADDR: sfr_rdata = ctrl_rd[0];
      CMPC_CTRL1_ADDR: sfr_rdata = ctrl_rd[1];
      CMPC_SPEED0_ADDR: sfr_rdata = speed_rd[0];
      CMPC_SPEED1_ADDR: sfr_rdata = speed_rd[1];
      default: sfr_rdata = 8'h00;
    endcase
  end

  // low result on enabled channel zero requests reset; uses the
  // synchronised result so glitches near threshold are filtered
  assign reset_req = reset_source_sel & power_on[0] & ~latched[0];

  assign latched_result_pin = latched[0];
  assign raw_result_pin = raw[0];
  assign latched_result_pin_b = latched[1];
  assign raw_result_pin_b = raw[1];
endmodule // cmpc_top

// *** sim/cmpc_analog_model.sv ***
/* cmpc_analog_model: analog core, result follows the input sign.
   assumes vin moves at the falling clock edge. */
`timescale 1ns/1ns
module cmpc_analog_model (
  // sign of the inputs, result out
  input wire logic [1:0] vin,
  output logic [1:0] compare_raw
);
  // settles a few ns after the input, well off the rising edge
  initial compare_raw = 2'h0;
  always @(vin) compare_raw <= #3 vin;
endmodule // cmpc_analog_model

// *** sim/cmpc_assertions.sv ***
/* cmpc_assertions: port checks on cmpc_top, channel zero.
   assumes the idle bus rests on address 8'h9b. */
`timescale 1ns/1ns
module cmpc_assertions (
  // clock, reset, bus
  input wire logic mclk, rst_b, sfr_wr,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  // channel zero and system
  input wire logic [1:0] compare_raw, power_on, irq_req,
  input wire logic reset_source_sel, reset_req, latched_result_pin, raw_result_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire cw = sfr_wr && sfr_addr == 8'h9b;
  // a level held two samples makes one synchronised edge
  sequence rise_s; $rose(compare_raw[0]) ##1 compare_raw[0]; endsequence
  sequence fall_s; $fell(compare_raw[0]) ##1 !compare_raw[0]; endsequence
  sequence idle_s; (sfr_addr == 8'h9b && !sfr_wr) [*2]; endsequence
  enable_write_a: assert property (cw |=> power_on[0] == $past(sfr_wdata[7]))
    else $error("enable ignored");
  raw_gate_a: assert property (raw_result_pin == (compare_raw[0] & power_on[0]))
    else $error("raw pin wrong");
  sync_path_a: assert property (rise_s ##0 !cw |=> latched_result_pin == power_on[0])
    else $error("latched pin wrong");
  rise_flag_a: assert property (rise_s ##1 idle_s |=> sfr_rdata[5])
    else $error("no rise flag");
  fall_flag_a: assert property (fall_s ##1 idle_s |=> sfr_rdata[4])
    else $error("no fall flag");
  irq_hold_a: assert property (irq_req[0] && !sfr_wr |=> irq_req[0])
    else $error("irq dropped");
  state_read_a: assert property (sfr_addr == 8'h9b && power_on[0] |-> sfr_rdata[6] == latched_result_pin)
    else $error("state bit wrong");
  reset_src_a: assert property (reset_req == (reset_source_sel && power_on[0] && !latched_result_pin))
    else $error("reset request wrong");
endmodule // cmpc_assertions
bind cmpc_top cmpc_assertions u_chk (.*);

// *** sim/test_cmpc_top.sv ***
/* test_cmpc_top: corner and random traffic on both channels.
   assumes the core model answers within a clock. */
`timescale 1ns/1ns
module test_cmpc_top
  import cmpc_pkg::*;
();
  // bus, core and shadow state
  logic mclk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, reset_source_sel = 1'b0, reset_req;
  logic [7:0] sfr_addr = 8'h9b, sfr_wdata = 8'h00, sfr_rdata, rc, rs;
  logic [7:0] ctl [2] = '{8'h00, 8'h00}, spd [2] = '{8'h02, 8'h02};
  logic [1:0] vin = 2'h0, compare_raw, power_on, irq_req;
  logic [3:0] positive_hysteresis_sel, negative_hysteresis_sel, response_speed_sel;
  logic latched_result_pin, raw_result_pin, latched_result_pin_b, raw_result_pin_b;
  int n_mismatch = 0, tests_run = 0;
  always #10 mclk = ~mclk;
  cmpc_top dut (.*);
  cmpc_analog_model u_core (.*);
  task automatic check(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // core-facing outputs and pins expected from the shadows
  function automatic logic [23:0] exp_ch(input int c);
    logic e;
    e = ctl[c][7] & vin[c];
    return {ctl[c][7], ctl[c][3:0], spd[c][1:0], |(ctl[c][5:4] & spd[c][5:4]), e, e, 14'h0};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_addr = 8'h9b;
  endtask
  // each read spans a rising edge so the checker sees it too
  task automatic check_ch(input int c);
    @(negedge mclk);
    sfr_addr = c ? 8'h9a : 8'h9b;
    @(negedge mclk);
    rc = sfr_rdata;
    sfr_addr = c ? 8'h9c : 8'h9d;
    @(negedge mclk);
    rs = sfr_rdata;
    sfr_addr = 8'h55;
    @(negedge mclk);
    check({rc, rs, sfr_rdata}, {ctl[c][7], vin[c], ctl[c][5:0], spd[c], 8'h00});
    sfr_addr = 8'h9b;
    check({power_on[c], positive_hysteresis_sel[2*c+:2], negative_hysteresis_sel[2*c+:2],
      response_speed_sel[2*c+:2], irq_req[c], c ? {latched_result_pin_b, raw_result_pin_b} :
      {latched_result_pin, raw_result_pin}, 14'h0}, exp_ch(c));
  endtask
  // kinds: control write, speed write, input toggle, unmapped write
  task automatic op(input int c, k, input logic [7:0] d);
    if (k == 0) begin
      wr(c ? 8'h9a : 8'h9b, d);
      ctl[c] = d;
    end else if (k == 1) begin
      wr(c ? 8'h9c : 8'h9d, d);
      spd[c] = d & 8'h33;
    end else if (k == 2) begin
      @(negedge mclk);
      vin[c] = ~vin[c];
      reset_source_sel = 1'($urandom);
      ctl[c] = ctl[c] | (vin[c] ? 8'h20 : 8'h10);
    end else wr(8'h55, d);
    repeat (5) @(posedge mclk);
    check_ch(0);
    check_ch(1);
    check({23'h0, reset_req}, {23'h0, reset_source_sel & ctl[0][7] & ~vin[0]});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd5a1becd));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    check_ch(0);
    check_ch(1);
    op(0, 0, 8'h80);
    op(0, 1, 8'h30);
    op(0, 2, 8'h00);
    op(0, 2, 8'h00);
    op(0, 0, 8'h9f);
    op(0, 0, 8'h8f);
    op(1, 3, 8'hff);
    // rising edge lands on the same edge as a write that clears the flag
    @(negedge mclk);
    vin[0] = 1'b1;
    @(negedge mclk);
    wr(8'h9b, 8'h80);
    ctl[0] = 8'ha0;
    repeat (5) @(posedge mclk);
    check_ch(0);
    repeat (60) op($urandom_range(1), $urandom_range(3), 8'($urandom));
    // mid-run reset; inputs parked low so release brings no false edge
    @(negedge mclk);
    rst_b = 1'b0;
    vin = 2'h0;
    ctl = '{8'h00, 8'h00};
    spd = '{8'h02, 8'h02};
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    check_ch(0);
    check_ch(1);
    op(1, 0, 8'h80);
    give_verdict();
  end
  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule // test_cmpc_top
